// file: logic/capability_regs.sv
// Read-only capability register bank behind the configuration register port
module capability_regs #(
  parameter logic [15:0] ASSEMBLY_TYPE     = 16'h0000,
  parameter logic [15:0] ASSEMBLY_MAKER    = 16'h0000,
  parameter logic [15:0] ASSEMBLY_REVISION = 16'h0000,
  parameter logic [15:0] EXT_FEAT_PTR      = cap_regs_pkg::EXT_FEAT_PTR_DEF,
  parameter logic        ROLE_BRIDGE       = 1'b0,
  parameter logic        ROLE_MEMORY       = 1'b1,
  parameter logic        ROLE_PROCESSOR    = 1'b0,
  parameter logic        CRIT_FLOW_SUPPORT = 1'b0,
  parameter logic        LARGE_SYSTEM      = 1'b0,
  parameter logic [12:0] ISSUE_OPS         = 13'h1fff
) (
  input  wire logic                              clock_i,
  input  wire logic                              nrst_i,
  input  wire logic                              cfg_req_i,
  input  wire logic                              cfg_we_i,
  input  wire logic [cap_regs_pkg::ADDR_W-1:0]   cfg_addr_i,
  input  wire logic [cap_regs_pkg::DATA_W-1:0]   cfg_wdata_i,
  output logic                                   cfg_rdy_o,
  output logic                                   cfg_ack_o,
  output logic                                   cfg_err_o,
  output logic      [cap_regs_pkg::DATA_W-1:0]   cfg_rdata_o,
  output logic                                   dev_id_wide_o
);

  typedef enum logic [1:0] {
    ST_LOAD,
    ST_IDLE,
    ST_READ,
    ST_DONE
  } bank_state_t;

  // ==========================================================
  // Declarations
  bank_state_t                                state_r;
  bank_state_t                                state_nxt;
  logic [cap_regs_pkg::WORD_IDX_W-1:0]        load_idx_r;
  logic [cap_regs_pkg::WORD_IDX_W-1:0]        load_idx_nxt;
  logic                                       rdy_r;
  logic                                       rdy_nxt;
  logic                                       ack_r;
  logic                                       ack_nxt;
  logic                                       err_r;
  logic                                       err_nxt;
  logic [cap_regs_pkg::DATA_W-1:0]            rdata_r;
  logic [cap_regs_pkg::DATA_W-1:0]            rdata_nxt;
  logic                                       wide_r;
  logic                                       wide_nxt;
  logic                                       pend_we_r;
  logic                                       pend_we_nxt;
  logic                                       pend_out_r;
  logic                                       pend_out_nxt;

  logic                                       take;
  logic                                       in_space;
  logic                                       store_rd_en;
  logic [cap_regs_pkg::WORD_IDX_W-1:0]        store_rd_idx;
  logic [cap_regs_pkg::DATA_W-1:0]            store_rd_data;
  logic                                       store_load_en;
  logic [cap_regs_pkg::DATA_W-1:0]            load_word;

  logic [cap_regs_pkg::DATA_W-1:0]            word_asm_id;
  logic [cap_regs_pkg::DATA_W-1:0]            word_asm_info;
  logic [cap_regs_pkg::DATA_W-1:0]            word_features;
  logic [cap_regs_pkg::DATA_W-1:0]            word_issue_ops;

  // ==========================================================
  // Word composition from the build-time configuration
  always_comb begin
    word_asm_id = {ASSEMBLY_TYPE, ASSEMBLY_MAKER};
  end

  always_comb begin
    word_asm_info = {ASSEMBLY_REVISION, EXT_FEAT_PTR};
  end

  always_comb begin
    word_features = cap_regs_pkg::WORD_ZERO;
    word_features[cap_regs_pkg::FEAT_BRIDGE]    = ROLE_BRIDGE;
    word_features[cap_regs_pkg::FEAT_MEMORY]    = ROLE_MEMORY;
    word_features[cap_regs_pkg::FEAT_PROCESSOR] = ROLE_PROCESSOR;
    word_features[cap_regs_pkg::FEAT_SWITCH]    = 1'b0;
    word_features[cap_regs_pkg::FEAT_MULTIPORT] = 1'b0;
    word_features[cap_regs_pkg::FEAT_CRIT_FLOW] = CRIT_FLOW_SUPPORT;
    word_features[cap_regs_pkg::FEAT_LARGE_SYS] = LARGE_SYSTEM;
    word_features[cap_regs_pkg::FEAT_EXT_FEAT]  = 1'b1;
    word_features[2:0]                          = cap_regs_pkg::EXT_ADDR_34_ONLY;
  end

  always_comb begin
    word_issue_ops = cap_regs_pkg::WORD_ZERO;
    word_issue_ops[cap_regs_pkg::OPS_FLAGS_LSB +: cap_regs_pkg::OPS_FLAGS_W] = ISSUE_OPS;
    word_issue_ops[cap_regs_pkg::OPS_PORT_WRITE] = 1'b0;
  end

  // ==========================================================
  // Load sequence word selection
  // Words not held by this bank, the switch port word among them, load as zero
  always_comb begin
    load_word = cap_regs_pkg::WORD_ZERO;
    case ({load_idx_r, 2'b00})
      cap_regs_pkg::OFS_ASSEMBLY_IDENTITY[5:0]: begin
        load_word = word_asm_id;
      end
      cap_regs_pkg::OFS_ASSEMBLY_INFO[5:0]: begin
        load_word = word_asm_info;
      end
      cap_regs_pkg::OFS_ELEMENT_FEATURES[5:0]: begin
        load_word = word_features;
      end
      cap_regs_pkg::OFS_ISSUABLE_OPS[5:0]: begin
        load_word = word_issue_ops;
      end
      default: begin
        load_word = cap_regs_pkg::WORD_ZERO;
      end
    endcase
  end

  // ==========================================================
  // Request decode
  always_comb begin
    take         = cfg_req_i && rdy_r;
    in_space     = (cfg_addr_i <= cap_regs_pkg::OFS_SPACE_LAST);
    store_rd_idx = cfg_addr_i[5:2];
    // Writes never reach the store; only reads fetch a word
    store_rd_en  = take && !cfg_we_i && in_space;
    store_load_en = (state_r == ST_LOAD);
  end

  // ==========================================================
  // Port sequencer
  always_comb begin
    state_nxt    = state_r;
    load_idx_nxt = load_idx_r;
    rdy_nxt      = rdy_r;
    ack_nxt      = 1'b0;
    err_nxt      = err_r;
    rdata_nxt    = rdata_r;
    pend_we_nxt  = pend_we_r;
    pend_out_nxt = pend_out_r;
    case (state_r)
      ST_LOAD: begin
        load_idx_nxt = load_idx_r + 1'b1;
        if (load_idx_r == cap_regs_pkg::WORD_IDX_W'(cap_regs_pkg::WORD_COUNT - 1)) begin
          state_nxt = ST_IDLE;
          rdy_nxt   = 1'b1;
        end
      end
      ST_IDLE: begin
        if (take) begin
          rdy_nxt      = 1'b0;
          pend_we_nxt  = cfg_we_i;
          pend_out_nxt = !in_space;
          state_nxt    = ST_READ;
        end
      end
      ST_READ: begin
        ack_nxt = 1'b1;
        err_nxt = pend_out_r;
        if (pend_we_r || pend_out_r) begin
          rdata_nxt = cap_regs_pkg::WORD_ZERO;
        end else begin
          rdata_nxt = store_rd_data;
        end
        state_nxt = ST_DONE;
      end
      ST_DONE: begin
        rdy_nxt   = 1'b1;
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
        rdy_nxt   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r    <= ST_LOAD;
      load_idx_r <= '0;
      rdy_r      <= 1'b0;
      ack_r      <= 1'b0;
      err_r      <= 1'b0;
      rdata_r    <= '0;
      pend_we_r  <= 1'b0;
      pend_out_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      load_idx_r <= load_idx_nxt;
      rdy_r      <= rdy_nxt;
      ack_r      <= ack_nxt;
      err_r      <= err_nxt;
      rdata_r    <= rdata_nxt;
      pend_we_r  <= pend_we_nxt;
      pend_out_r <= pend_out_nxt;
    end
  end

  // ==========================================================
  // Identifier width select for the transport layer
  always_comb begin
    wide_nxt = LARGE_SYSTEM;
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wide_r <= 1'b0;
    end else begin
      wide_r <= wide_nxt;
    end
  end

  // ==========================================================
  // Word store
  cap_word_store #(
    .WIDTH (cap_regs_pkg::DATA_W),
    .DEPTH (cap_regs_pkg::WORD_COUNT),
    .IDX_W (cap_regs_pkg::WORD_IDX_W)
  ) u_store (
    .clock_i     (clock_i),
    .nrst_i      (nrst_i),
    .load_en_i   (store_load_en),
    .load_idx_i  (load_idx_r),
    .load_data_i (load_word),
    .rd_en_i     (store_rd_en),
    .rd_idx_i    (store_rd_idx),
    .rd_data_o   (store_rd_data)
  );

  // ==========================================================
  // Outputs
  assign cfg_rdy_o     = rdy_r;
  assign cfg_ack_o     = ack_r;
  assign cfg_err_o     = err_r;
  assign cfg_rdata_o   = rdata_r;
  assign dev_id_wide_o = wide_r;

endmodule // capability_regs

// file: logic/cap_regs_pkg.sv
// Constants for the read-only capability register bank
// Behaviour
// - The assembly identity word returns the assembly type code in bits 31:16 and the assembly maker code in 15:0.
// - The assembly information word returns the assembly revision in 31:16 and the feature pointer, default 0x0100.
// - Features bits 31, 30 and 29 report the bridge, memory and processor roles, each chosen on its own.
// - Features bit 28, the switch flag, always reads zero.
// - Features bit 27, the multiport flag, always reads zero.
// - Features bits 26 to 7 and bit 6 always read zero.
// - Features bit 5 reports whether the critical request flow indicator is supported.
// - Features bit 4 reports the large system option, which also selects 16-bit device identifiers.
// - Features bit 3 is constant one, marking the extended feature pointer as valid.
// - Features bits 2 to 0 are fixed at 3'b001, advertising 34-bit addressing only.
// - The switch port word means nothing while the switch flag is zero, so nobody may rely on its content.
// - The issuable operations word reports support flags in bits 15 to 3 that change no behaviour.
// - Bit 2 of the issuable operations word, the port-write flag, always reads zero.
// - Bits 31 to 18, 17 to 16 and 1 to 0 of the issuable operations word read zero.
// - Every capability word is read-only and served through the configuration register port.
package cap_regs_pkg;

  // ==========================================================
  // Port geometry
  localparam int unsigned ADDR_W      = 24;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned WORD_IDX_W  = 4;
  localparam int unsigned WORD_COUNT  = 16;

  // ==========================================================
  // Byte offsets of the capability space
  localparam logic [ADDR_W-1:0] OFS_DEVICE_IDENTITY   = 24'h000000;
  localparam logic [ADDR_W-1:0] OFS_DEVICE_INFO       = 24'h000004;
  localparam logic [ADDR_W-1:0] OFS_ASSEMBLY_IDENTITY = 24'h000008;
  localparam logic [ADDR_W-1:0] OFS_ASSEMBLY_INFO     = 24'h00000c;
  localparam logic [ADDR_W-1:0] OFS_ELEMENT_FEATURES  = 24'h000010;
  localparam logic [ADDR_W-1:0] OFS_SWITCH_PORT_INFO  = 24'h000014;
  localparam logic [ADDR_W-1:0] OFS_ISSUABLE_OPS      = 24'h000018;
  localparam logic [ADDR_W-1:0] OFS_SPACE_LAST        = 24'h00003c;

  // ==========================================================
  // Field positions
  localparam int unsigned HALF_HI_LSB      = 16;
  localparam int unsigned FEAT_BRIDGE      = 31;
  localparam int unsigned FEAT_MEMORY      = 30;
  localparam int unsigned FEAT_PROCESSOR   = 29;
  localparam int unsigned FEAT_SWITCH      = 28;
  localparam int unsigned FEAT_MULTIPORT   = 27;
  localparam int unsigned FEAT_CRIT_FLOW   = 5;
  localparam int unsigned FEAT_LARGE_SYS   = 4;
  localparam int unsigned FEAT_EXT_FEAT    = 3;
  localparam int unsigned OPS_FLAGS_LSB    = 3;
  localparam int unsigned OPS_FLAGS_W      = 13;
  localparam int unsigned OPS_PORT_WRITE   = 2;

  // ==========================================================
  // Fixed values and defaults
  localparam logic [15:0] EXT_FEAT_PTR_DEF = 16'h0100;
  localparam logic [2:0]  EXT_ADDR_34_ONLY = 3'b001;
  localparam logic [DATA_W-1:0] WORD_ZERO  = 32'h00000000;

endpackage

// file: logic/cap_word_store.sv
// Small word store with registered read data
module cap_word_store #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned IDX_W = 4
) (
  input  wire logic             clock_i,
  input  wire logic             nrst_i,
  input  wire logic             load_en_i,
  input  wire logic [IDX_W-1:0] load_idx_i,
  input  wire logic [WIDTH-1:0] load_data_i,
  input  wire logic             rd_en_i,
  input  wire logic [IDX_W-1:0] rd_idx_i,
  output logic      [WIDTH-1:0] rd_data_o
);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] rd_data_r;
  logic [WIDTH-1:0] rd_data_nxt;

  // ==========================================================
  // Read path
  always_comb begin
    rd_data_nxt = rd_data_r;
    if (rd_en_i) begin
      rd_data_nxt = mem_r[rd_idx_i];
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_data_r <= '0;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  // ==========================================================
  // Storage, filled only by the load port
  always_ff @(posedge clock_i) begin
    if (load_en_i) begin
      mem_r[load_idx_i] <= load_data_i;
    end
  end

  assign rd_data_o = rd_data_r;

endmodule // cap_word_store

// file: tb/capability_regs_props.sv
// Checker for the capability register bank port
module capability_regs_props (
  input wire logic                            clock_i,
  input wire logic                            nrst_i,
  input wire logic                            cfg_req_i,
  input wire logic                            cfg_we_i,
  input wire logic [cap_regs_pkg::ADDR_W-1:0] cfg_addr_i,
  input wire logic [cap_regs_pkg::DATA_W-1:0] cfg_wdata_i,
  input wire logic                            cfg_rdy_o,
  input wire logic                            cfg_ack_o,
  input wire logic                            cfg_err_o,
  input wire logic [cap_regs_pkg::DATA_W-1:0] cfg_rdata_o,
  input wire logic                            dev_id_wide_o
);
  logic tk;
  logic rd_ft;
  logic rd_op;
  assign tk    = cfg_req_i && cfg_rdy_o;
  assign rd_ft = tk && !cfg_we_i && cfg_addr_i == 24'h000010;
  assign rd_op = tk && !cfg_we_i && cfg_addr_i == 24'h000018;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  // ==========================================================
  // Answer timing and word contents
  a_ack_in_time: assert property (tk |-> ##[2:3] cfg_ack_o)
    else $error("no answer in time");
  a_switch_zero: assert property (rd_ft |-> ##[2:3] cfg_ack_o && !cfg_rdata_o[28])
    else $error("switch flag set");
  a_multi_zero: assert property (rd_ft |-> ##[2:3] cfg_ack_o && !cfg_rdata_o[27])
    else $error("multiport flag set");
  a_feat_resv_zero: assert property (rd_ft |-> ##[2:3] cfg_ack_o && cfg_rdata_o[26:6] == 21'h0)
    else $error("reserved feature bits set");
  a_ext_feat_one: assert property (rd_ft |-> ##[2:3] cfg_ack_o && cfg_rdata_o[3])
    else $error("extended feature flag clear");
  a_addr_mode_fixed: assert property (rd_ft |-> ##[2:3] cfg_ack_o && cfg_rdata_o[2:0] == 3'h1)
    else $error("addressing field wrong");
  a_wide_id_match: assert property (rd_ft |-> ##[2:3] cfg_ack_o && cfg_rdata_o[4] == dev_id_wide_o)
    else $error("wide id output differs from feature bit");
  a_port_write_zero: assert property (rd_op |-> ##[2:3] cfg_ack_o && !cfg_rdata_o[2])
    else $error("port-write flag set");
  a_ops_resv_zero: assert property (rd_op |-> ##[2:3] cfg_ack_o && cfg_rdata_o[31:16] == 16'h0
    && cfg_rdata_o[1:0] == 2'h0)
    else $error("reserved operation bits set");
  a_write_quiet: assert property (tk && cfg_we_i |-> ##[2:3] cfg_ack_o && cfg_rdata_o == 32'h0)
    else $error("write returned data");

  c_read_feat: cover property (rd_ft);
  c_read_ops: cover property (rd_op);
  c_write: cover property (tk && cfg_we_i);
endmodule // capability_regs_props

bind capability_regs capability_regs_props capability_regs_props_i (
  .clock_i(clock_i), .nrst_i(nrst_i), .cfg_req_i(cfg_req_i), .cfg_we_i(cfg_we_i),
  .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdy_o(cfg_rdy_o), .cfg_ack_o(cfg_ack_o),
  .cfg_err_o(cfg_err_o), .cfg_rdata_o(cfg_rdata_o), .dev_id_wide_o(dev_id_wide_o)
);

// file: tb/tb.sv
// Self-checking bench for the capability register bank
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i, nrst_i, cfg_req_i, cfg_we_i;
  logic [23:0] cfg_addr_i;
  logic [31:0] cfg_wdata_i, cfg_rdata_o;
  logic        cfg_rdy_o, cfg_ack_o, cfg_err_o, dev_id_wide_o;
  int          n_fail, n_compared, cyc;
  localparam logic [23:0] ADR [4] = '{24'h000008, 24'h00000c, 24'h000010, 24'h000018};
  // Assembly maker and the three roles stay at their defaults: maker 0, memory role only
  localparam logic [31:0] EXP [4] = '{32'h12340000, 32'h9abc0100, {3'h2, 23'h0, 3'h7, 3'h1},
                                      {16'h0, 13'h0a5b, 3'h0}};

  capability_regs #(.ASSEMBLY_TYPE(16'h1234), .ASSEMBLY_REVISION(16'h9abc),
    .CRIT_FLOW_SUPPORT(1'b1), .LARGE_SYSTEM(1'b1), .ISSUE_OPS(13'h0a5b)) capability_regs_i (
    .clock_i(clock_i), .nrst_i(nrst_i), .cfg_req_i(cfg_req_i), .cfg_we_i(cfg_we_i),
    .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdy_o(cfg_rdy_o), .cfg_ack_o(cfg_ack_o),
    .cfg_err_o(cfg_err_o), .cfg_rdata_o(cfg_rdata_o), .dev_id_wide_o(dev_id_wide_o));

  // ==========================================================
  // Clock, timeout and reporting
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic close_out;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask

  // ==========================================================
  // One request, raised for one clock once ready is seen, then wait for the answer
  task automatic xfer(input logic we, input logic [23:0] a, output logic [31:0] d, output logic e);
    int n;
    n = 0;
    while (cfg_rdy_o !== 1'b1 && n < 40) begin
      @(negedge clock_i);
      n++;
    end
    cfg_req_i   = 1'b1;
    cfg_we_i    = we;
    cfg_addr_i  = a;
    cfg_wdata_i = 32'hffffffff;
    @(negedge clock_i);
    cfg_req_i = 1'b0;
    n = 0;
    while (cfg_ack_o !== 1'b1 && n < 5) begin
      @(negedge clock_i);
      n++;
    end
    d = cfg_rdata_o;
    e = cfg_err_o;
    chk1("ack", 1'b1, cfg_ack_o);
    @(negedge clock_i);
  endtask

  task automatic rd(input logic [23:0] a, input logic [31:0] x);
    logic [31:0] d;
    logic        e;
    xfer(1'b0, a, d, e);
    chk32("read word", x, d);
    chk1("read err", 1'b0, e);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_read_words;
    for (int i = 0; i < 4; i++) begin
      rd(ADR[i], EXP[i]);
    end
    chk1("wide id", 1'b1, dev_id_wide_o);
    rd(24'h000014, 32'h0);
  endtask

  task automatic t_writes_ignored;
    logic [31:0] d;
    logic        e;
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, ADR[i], d, e);
      chk32("write data", 32'h0, d);
      chk1("write err", 1'b0, e);
      rd(ADR[i], EXP[i]);
    end
  endtask

  task automatic t_out_of_space;
    logic [31:0] d;
    logic        e;
    xfer(1'b0, 24'h000040, d, e);
    chk1("range err", 1'b1, e);
    chk32("range data", 32'h0, d);
    rd(24'h00003c, 32'h0);
  endtask

  initial begin
    nrst_i      = 1'b0;
    cfg_req_i   = 1'b0;
    cfg_we_i    = 1'b0;
    cfg_addr_i  = 24'h0;
    cfg_wdata_i = 32'h0;
    repeat (10) @(negedge clock_i);
    nrst_i = 1'b1;
    t_read_words();
    t_writes_ignored();
    t_out_of_space();
    close_out();
  end
endmodule // tb
